// [verilog/sfd_pkg.sv]
package sfd_pkg;
	// ------------------------------------------------------------
	// Widths and sizes
	// ------------------------------------------------------------
	localparam int          WORD_W      = 16;           // Sample word width
	localparam int          ADDR_W      = 10;           // Mother block address width
	localparam int          MEM_DEPTH   = 1024;         // Mother block store depth
	localparam logic [9:0]  SLOT_LAST   = 10'd689;      // Last of 690 container slots
	localparam logic [9:0]  PAY_LEN     = 10'd432;      // Type-4 bits per time slot
	localparam logic [9:0]  STEAL_SKIP  = 10'd216;      // First half dropped when stealing
	// ------------------------------------------------------------
	// Soft values
	// ------------------------------------------------------------
	localparam logic [15:0] SOFT_ONE    = 16'h007f;     // Binary one as +127
	localparam logic [15:0] SOFT_ZERO   = 16'hff81;     // Binary zero as -127
	// ------------------------------------------------------------
	// Container marker slots (0-based) and marker words
	// ------------------------------------------------------------
	localparam logic [9:0]  MK_SLOT [6] = '{10'd0, 10'd115, 10'd230, 10'd345, 10'd460, 10'd575};
	localparam logic [15:0] MK_WORD [6] = '{16'h6b21, 16'h6b22, 16'h6b23,
	                                        16'h6b24, 16'h6b25, 16'h6b26};
	localparam logic [9:0]  RUN_END [4] = '{10'd115, 10'd230, 10'd345, 10'd436};
	// ------------------------------------------------------------
	// Class boundaries in payload index and mother block address, normal and stealing
	// ------------------------------------------------------------
	localparam logic [9:0]  C0_NORM     = 10'd102;
	localparam logic [9:0]  C1_NORM     = 10'd270;      // 102 + 168
	localparam logic [9:0]  C0_STEAL    = 10'd51;
	localparam logic [9:0]  C1_STEAL    = 10'd135;      // 51 + 84
	localparam logic [9:0]  B2_NORM     = 10'd438;      // 102 + 3*112
	localparam logic [9:0]  B2_STEAL    = 10'd219;      // 51 + 3*56
	localparam logic [9:0]  LEN_NORM    = 10'd654;      // 438 + 3*72
	localparam logic [9:0]  LEN_STEAL   = 10'd333;      // 219 + 3*38
	// ------------------------------------------------------------
	// Puncturing coefficients (1-based positions in a period)
	// ------------------------------------------------------------
	localparam logic [4:0]  T_R23       = 5'd3;
	localparam logic [4:0]  PER_R23     = 5'd6;
	localparam logic [4:0]  P_R23 [3]   = '{5'd1, 5'd2, 5'd4};
	localparam logic [4:0]  T_R818      = 5'd9;
	localparam logic [4:0]  PER_R818    = 5'd12;
	localparam logic [4:0]  P_R818 [9]  = '{5'd1, 5'd2, 5'd3, 5'd4, 5'd5, 5'd7, 5'd8,
	                                        5'd10, 5'd11};
	localparam logic [4:0]  T_R817      = 5'd17;
	localparam logic [4:0]  PER_R817    = 5'd24;
	localparam logic [4:0]  P_R817 [17] = '{5'd1, 5'd2, 5'd3, 5'd4, 5'd5, 5'd7, 5'd8,
	                                        5'd10, 5'd11, 5'd13, 5'd14, 5'd16, 5'd17,
	                                        5'd19, 5'd20, 5'd22, 5'd23};
	// ------------------------------------------------------------
	// Receive sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SFD_CLEAR = 2'b00,
		SFD_FILL  = 2'b01,
		SFD_DRAIN = 2'b11
	} sfd_state_t;
endpackage : sfd_pkg

// [verilog/sfd_mem.sv]
`timescale 1ns/1ps
module sfd_mem
	import sfd_pkg::*;
(
	// Clock
	input  wire logic              mclk,
	// Write port
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] waddr,
	input  wire logic [WORD_W-1:0] wdata,
	// Read port
	input  wire logic              re,
	input  wire logic [ADDR_W-1:0] raddr,
	output logic      [WORD_W-1:0] rdata_q
);
	logic [WORD_W-1:0] mem [MEM_DEPTH];    // Mother block storage

	// Synchronous write, registered read
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		if (re) begin
			rdata_q <= mem[raddr];
		end
	end
endmodule : sfd_mem

// [verilog/sfd_depuncture.sv]
// Functional notes
// - Leading bad frame slot, zero on encode; the transmit packer sends the input bit as given
// - One coded bit per 16-bit word LSB
// - 432 type-4 bits in 690 slots
// - Markers at fixed slots, zero fill runs
// - Binary values carried as soft +/-127
// - Receive strips markers, recovers payload, flag
// - Depuncture to rate 1/3 for Viterbi
// - Working block cleared before placement
// - Placement address from period and coefficients
// - Coefficients lie within 1 to 24
// - Datapath uses 16-bit signed values
// - Rate 2/3: coefficients 1,2,4, period 6
// - Rate 8/18: nine coefficients, period 12
// - Normal: 102 plain, 168 r2/3, 162 r8/18
// - Stealing: rate 8/17, seventeen coefficients, period 24
`timescale 1ns/1ps
module sfd_depuncture
	import sfd_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_n,
	// Transmit bits in, one per word
	input  wire logic [WORD_W-1:0] tx_in_word,
	input  wire logic              tx_in_valid,
	output logic                   tx_in_ready,
	// Transmit container out
	output logic      [WORD_W-1:0] tx_out_word,
	output logic                   tx_out_valid,
	input  wire logic              tx_out_ready,
	// Receive container in
	input  wire logic [WORD_W-1:0] rx_in_word,
	input  wire logic              rx_in_valid,
	output logic                   rx_in_ready,
	input  wire logic              frame_steal,
	// Mother block out
	output logic      [WORD_W-1:0] mb_word,
	output logic                   mb_valid,
	input  wire logic              mb_ready,
	output logic                   mb_block_ready,
	output logic                   bad_frame_flag
);
	// ------------------------------------------------------------
	// Slot classification helpers
	// ------------------------------------------------------------
	// Marker word of a slot, or zero when the slot carries none
	function automatic logic [16:0] mk_of(input logic [9:0] s);
		mk_of = 17'h00000;
		for (int i = 0; i < 6; i++) begin
			if (s == MK_SLOT[i]) begin
				mk_of = {1'b1, MK_WORD[i]};
			end
		end
	endfunction : mk_of

	// Payload index of a slot; bit 10 set when slot is payload
	function automatic logic [10:0] pay_of(input logic [9:0] s);
		pay_of = 11'h000;
		if (s >= 10'd1 && s < RUN_END[0]) begin
			pay_of = {1'b1, s - 10'd1};
		end else if (s > RUN_END[0] && s < RUN_END[1]) begin
			pay_of = {1'b1, s - 10'd2};
		end else if (s > RUN_END[1] && s < RUN_END[2]) begin
			pay_of = {1'b1, s - 10'd3};
		end else if (s > RUN_END[2] && s < RUN_END[3]) begin
			pay_of = {1'b1, s - 10'd4};
		end
	endfunction : pay_of

	// ------------------------------------------------------------
	// Transmit packer state
	// ------------------------------------------------------------
	logic [9:0]        tslot_q, tslot_d;       // Container slot being emitted
	logic              thave_q, thave_d;       // Input bit held
	logic              tbit_q, tbit_d;         // Held input bit
	logic [WORD_W-1:0] tword_q, tword_d;       // Output word
	logic              tval_q, tval_d;         // Output word valid
	logic              trdy_q, trdy_d;         // Input ready, registered copy of ~have
	logic [16:0]       t_mk;
	logic [10:0]       t_pay;
	logic              t_load;

	// Next transmit values
	always_comb begin
		tslot_d = tslot_q;
		thave_d = thave_q;
		tbit_d  = tbit_q;
		tword_d = tword_q;
		tval_d  = tval_q;
		t_mk    = mk_of(tslot_q);
		t_pay   = pay_of(tslot_q);
		t_load  = 1'b0;
		// Capture one input bit from the LSB of its word
		if (!thave_q && tx_in_valid) begin
			thave_d = 1'b1;
			tbit_d  = tx_in_word[0];
		end
		if (tval_q && tx_out_ready) begin
			tval_d = 1'b0;
		end
		// Emit next slot when output register is free
		if (!tval_q || tx_out_ready) begin
			if (t_mk[16]) begin
				tword_d = t_mk[15:0];
				t_load  = 1'b1;
			end else if (t_pay[10]) begin
				if (thave_q) begin
					tword_d = tbit_q ? SOFT_ONE : SOFT_ZERO;
					thave_d = 1'b0;
					t_load  = 1'b1;
				end
			end else begin
				tword_d = 16'h0000;
				t_load  = 1'b1;
			end
		end
		if (t_load) begin
			tval_d  = 1'b1;
			tslot_d = (tslot_q == SLOT_LAST) ? 10'd0 : tslot_q + 10'd1;
		end
		// Ready mirrors an empty holding register, kept in a flop
		trdy_d = ~thave_d;
	end

	// Register transmit state
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tslot_q <= 10'd0;
			thave_q <= 1'b0;
			tbit_q  <= 1'b0;
			tword_q <= 16'h0000;
			tval_q  <= 1'b0;
			trdy_q  <= 1'b1;
		end else begin
			tslot_q <= tslot_d;
			thave_q <= thave_d;
			tbit_q  <= tbit_d;
			tword_q <= tword_d;
			tval_q  <= tval_d;
			trdy_q  <= trdy_d;
		end
	end

	assign tx_in_ready  = trdy_q;
	assign tx_out_word  = tword_q;
	assign tx_out_valid = tval_q;

	// ------------------------------------------------------------
	// Receive sequencer and depuncturer state
	// ------------------------------------------------------------
	sfd_state_t        st_q, st_d;            // Sequencer state
	logic [9:0]        rslot_q, rslot_d;      // Container slot / clear / read address
	logic              steal_q, steal_d;      // Stealing mode latched per block
	logic [4:0]        idx_q, idx_d;          // Coefficient index in period
	logic [9:0]        base_q, base_d;        // Period base in current class
	logic              rdy_q, rdy_d;          // Receive ready
	logic              strobe_q, strobe_d;    // Block ready strobe
	logic              bff_q, bff_d;          // Bad frame flag
	logic              pend_q, pend_d;        // Read in flight
	logic [WORD_W-1:0] e0_q, e0_d, e1_q, e1_d; // Two-entry output buffer
	logic              v0_q, v0_d, v1_q, v1_d;
	logic [10:0]       r_pay;
	logic [9:0]        n, c0, c1, len;
	logic [4:0]        t_now, per_now, p_now;
	logic              we, re;
	logic [9:0]        waddr, raddr;
	logic [WORD_W-1:0] wdata, rdata;
	logic              pop, hv, tv;
	logic [WORD_W-1:0] hd;

	// Next receive values
	always_comb begin
		st_d     = st_q;
		rslot_d  = rslot_q;
		steal_d  = steal_q;
		idx_d    = idx_q;
		base_d   = base_q;
		strobe_d = 1'b0;
		bff_d    = bff_q;
		pend_d   = 1'b0;
		we       = 1'b0;
		re       = 1'b0;
		waddr    = rslot_q;
		wdata    = 16'h0000;
		raddr    = rslot_q;
		r_pay    = pay_of(rslot_q);
		c0       = steal_q ? C0_STEAL : C0_NORM;
		c1       = steal_q ? C1_STEAL : C1_NORM;
		len      = steal_q ? LEN_STEAL : LEN_NORM;
		n        = r_pay[9:0] - (steal_q ? STEAL_SKIP : 10'd0);
		// Pick code for the class of this payload word
		if (n < c1) begin
			t_now   = T_R23;
			per_now = PER_R23;
			p_now   = P_R23[idx_q[1:0]];
		end else if (steal_q) begin
			t_now   = T_R817;
			per_now = PER_R817;
			p_now   = P_R817[idx_q];
		end else begin
			t_now   = T_R818;
			per_now = PER_R818;
			p_now   = P_R818[idx_q[3:0]];
		end
		// Output buffer bookkeeping
		pop = v0_q & mb_ready;
		hv  = pop ? v1_q : v0_q;
		hd  = pop ? e1_q : e0_q;
		tv  = pop ? 1'b0 : v1_q;
		e0_d = hd;
		e1_d = e1_q;
		v0_d = hv;
		v1_d = tv;
		if (pend_q) begin
			if (!hv) begin
				e0_d = rdata;
				v0_d = 1'b1;
			end else begin
				e1_d = rdata;
				v1_d = 1'b1;
			end
		end
		case (st_q)
			SFD_CLEAR: begin
				we = 1'b1;
				if (rslot_q == len - 10'd1) begin
					st_d    = SFD_FILL;
					rslot_d = 10'd0;
				end else begin
					rslot_d = rslot_q + 10'd1;
				end
			end
			SFD_FILL: begin
				if (rx_in_valid) begin
					// Markers, zero runs and the first half when stealing are dropped, other payload placed
					if (r_pay[10] && !(steal_q && r_pay[9:0] < STEAL_SKIP)) begin
						we    = 1'b1;
						wdata = rx_in_word;
						if (n == 10'd0) begin
							bff_d = ~rx_in_word[15];
						end
						if (n < c0) begin
							waddr = n;
						end else begin
							// Class 1 starts at c0, class 2 after 3*K3 of class 1
							waddr = (n < c1 ? c0 : (steal_q ? B2_STEAL : B2_NORM))
							        + base_q + {5'd0, p_now} - 10'd1;
							if (n == c1 - 10'd1) begin
								idx_d  = 5'd0;
								base_d = 10'd0;
							end else if (idx_q == t_now - 5'd1) begin
								idx_d  = 5'd0;
								base_d = base_q + {5'd0, per_now};
							end else begin
								idx_d = idx_q + 5'd1;
							end
						end
					end
					if (rslot_q == SLOT_LAST) begin
						st_d     = SFD_DRAIN;
						rslot_d  = 10'd0;
						strobe_d = 1'b1;
					end else begin
						rslot_d = rslot_q + 10'd1;
					end
				end
			end
			SFD_DRAIN: begin
				// Issue a read only when the buffer has a free entry
				if ({1'b0, v0_q} + {1'b0, v1_q} + {1'b0, pend_q} < 2'd2
				    && rslot_q != len) begin
					re      = 1'b1;
					pend_d  = 1'b1;
					rslot_d = rslot_q + 10'd1;
				end
				// Block consumed: start over with a fresh clear
				if (rslot_q == len && !pend_q && !v0_d) begin
					st_d    = SFD_CLEAR;
					rslot_d = 10'd0;
					steal_d = frame_steal;
					idx_d   = 5'd0;
					base_d  = 10'd0;
				end
			end
			default: begin
				st_d    = SFD_CLEAR;
				rslot_d = 10'd0;
			end
		endcase
		rdy_d = (st_d == SFD_FILL);
	end

	// Register receive state
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q     <= SFD_CLEAR;
			rslot_q  <= 10'd0;
			steal_q  <= 1'b0;
			idx_q    <= 5'd0;
			base_q   <= 10'd0;
			rdy_q    <= 1'b0;
			strobe_q <= 1'b0;
			bff_q    <= 1'b0;
			pend_q   <= 1'b0;
			e0_q     <= 16'h0000;
			e1_q     <= 16'h0000;
			v0_q     <= 1'b0;
			v1_q     <= 1'b0;
		end else begin
			st_q     <= st_d;
			rslot_q  <= rslot_d;
			steal_q  <= steal_d;
			idx_q    <= idx_d;
			base_q   <= base_d;
			rdy_q    <= rdy_d;
			strobe_q <= strobe_d;
			bff_q    <= bff_d;
			pend_q   <= pend_d;
			e0_q     <= e0_d;
			e1_q     <= e1_d;
			v0_q     <= v0_d;
			v1_q     <= v1_d;
		end
	end

	// ------------------------------------------------------------
	// Mother block store
	// ------------------------------------------------------------
	sfd_mem sfd_mem_inst (
		.mclk    (mclk),
		.we      (we),
		.waddr   (waddr),
		.wdata   (wdata),
		.re      (re),
		.raddr   (raddr),
		.rdata_q (rdata)
	);

	assign rx_in_ready    = rdy_q;
	assign mb_word        = e0_q;
	assign mb_valid       = v0_q;
	assign mb_block_ready = strobe_q;
	assign bad_frame_flag = bff_q;
endmodule : sfd_depuncture

// [dv/sfd_depuncture_assertions.sv]
`timescale 1ns/1ps
module sfd_depuncture_assertions
	import sfd_pkg::*;
(
	// Clock and reset
	input wire logic              mclk,
	input wire logic              rst_n,
	// Transmit side
	input wire logic              tx_in_valid,
	input wire logic              tx_in_ready,
	input wire logic [WORD_W-1:0] tx_out_word,
	input wire logic              tx_out_valid,
	input wire logic              tx_out_ready,
	// Receive side
	input wire logic              rx_in_ready,
	input wire logic [WORD_W-1:0] mb_word,
	input wire logic              mb_valid,
	input wire logic              mb_ready,
	input wire logic              mb_block_ready
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Holding register fills on a take
	property p_tx_take; tx_in_valid && tx_in_ready |=> !tx_in_ready; endproperty
	a_tx_take: assert property (p_tx_take) else $error("tx bit not held");
	// Container word waits for the sink
	property p_tx_hold; tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out_word);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx word dropped");
	// Only markers, soft values or zero leave
	property p_tx_vals; tx_out_valid |-> tx_out_word inside {16'h6b21, 16'h6b22, 16'h6b23,
		16'h6b24, 16'h6b25, 16'h6b26, 16'h007f, 16'hff81, 16'h0000}; endproperty
	a_tx_vals: assert property (p_tx_vals) else $error("bad tx word");
	// Block strobe lasts one cycle
	property p_blk_pulse; mb_block_ready |=> !mb_block_ready; endproperty
	a_blk_pulse: assert property (p_blk_pulse) else $error("strobe too long");
	// No input while a block is out
	property p_blk_rx; mb_block_ready |-> !rx_in_ready ##1 !rx_in_ready; endproperty
	a_blk_rx: assert property (p_blk_rx) else $error("input open at strobe");
	// Mother block starts soon after the strobe
	property p_mb_first; mb_block_ready |-> ##[1:8] mb_valid; endproperty
	a_mb_first: assert property (p_mb_first) else $error("no mother word");
	// Stalled mother word is kept
	property p_mb_hold; mb_valid && !mb_ready |=> mb_valid && $stable(mb_word); endproperty
	a_mb_hold: assert property (p_mb_hold) else $error("mother word lost");
	// Filling only once the block is gone
	property p_rx_mb; rx_in_ready |-> !mb_valid && !mb_block_ready; endproperty
	a_rx_mb: assert property (p_rx_mb) else $error("fill during drain");
	c_blk: cover property (mb_block_ready);
	c_mb_stall: cover property (mb_valid && !mb_ready);
	c_tx_stall: cover property (tx_out_valid && !tx_out_ready);
endmodule : sfd_depuncture_assertions

// [dv/sfd_partner.sv]
`timescale 1ns/1ps
module sfd_partner
	import sfd_pkg::*;
(
	// Clock and reset
	input wire logic              mclk,
	input wire logic              rst_n,
	// Source coder side
	output logic     [WORD_W-1:0] tx_in_word,
	output logic                  tx_in_valid,
	input wire logic              tx_in_ready,
	// Decoder side
	input wire logic              stall,
	output logic                  mb_ready
);
	logic [9:0] k_q; // Bit index in container, source coder bit stream
	logic [1:0] s_q; // Stall phase
	// First bit is the zeroed flag slot; upper bits are filler
	assign tx_in_word = {15'h2d5a, (k_q != 10'h0) & (k_q[0] ^ k_q[2])};
	// Decoder stalls half the time when asked
	assign mb_ready = !(stall && s_q[1]);
	// Offer bits back to back
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			k_q <= 10'h0;
			s_q <= 2'h0;
			tx_in_valid <= 1'b0;
		end else begin
			tx_in_valid <= 1'b1;
			s_q <= s_q + 2'h1;
			if (tx_in_valid && tx_in_ready)
				k_q <= (k_q == PAY_LEN - 10'h1) ? 10'h0 : k_q + 10'h1;
		end
	end
endmodule : sfd_partner

// [dv/tb_sfd_depuncture.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin \
	checks++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("unexpected at %0t got %h exp %h", $time, g, e); \
	end \
end
module tb_sfd_depuncture
	import sfd_pkg::*;
();
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic              mclk = 1'b0, rst_n = 1'b0, tx_out_ready = 1'b0, rx_in_valid = 1'b0;
	logic              frame_steal = 1'b0, mb_ready, stall = 1'b0;
	logic [WORD_W-1:0] rx_in_word = 16'h0, tx_in_word, tx_out_word, mb_word;
	logic              tx_in_valid, tx_in_ready, tx_out_valid, rx_in_ready, mb_valid;
	logic              mb_block_ready, bad_frame_flag;
	int                checks = 0, miscompares = 0, cyc = 0;
	logic [WORD_W-1:0] exp_q [MEM_DEPTH]; // Expected mother block
	int                p23 [3] = '{1, 2, 4};
	int                p818 [9] = '{1, 2, 3, 4, 5, 7, 8, 10, 11};
	int                p817 [17] = '{1, 2, 3, 4, 5, 7, 8, 10, 11, 13, 14, 16, 17, 19, 20, 22, 23};
	sfd_depuncture sfd_depuncture_inst (.mclk, .rst_n, .tx_in_word, .tx_in_valid, .tx_in_ready,
		.tx_out_word, .tx_out_valid, .tx_out_ready, .rx_in_word, .rx_in_valid, .rx_in_ready,
		.frame_steal, .mb_word, .mb_valid, .mb_ready, .mb_block_ready, .bad_frame_flag);
	sfd_partner sfd_partner_inst (.mclk, .rst_n, .tx_in_word, .tx_in_valid, .tx_in_ready,
		.stall, .mb_ready);
	always #5 mclk = ~mclk;
	// Cut a hang short
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up();
		end
	end
	// Payload index of a container slot, or -1
	function automatic int pidx(input int s);
		for (int r = 0; r < 4; r++)
			if (s > 115 * r && s < (r == 3 ? 436 : 115 * r + 115)) return s - 1 - r;
		return -1;
	endfunction : pidx
	// Expected transmit word of a slot
	function automatic logic [15:0] tx_exp(input int s);
		int p;
		p = pidx(s);
		for (int i = 0; i < 6; i++) if (s == 115 * i) return 16'h6b21 + 16'(i);
		if (p < 0) return 16'h0;
		return ((p != 0) && (p[0] ^ p[2])) ? 16'h007f : 16'hff81;
	endfunction : tx_exp
	// Received soft value of a payload index, sign varies
	function automatic logic [15:0] rx_val(input int p);
		logic [15:0] v;
		v = 16'(p + 1);
		return p[3] ? -v : v;
	endfunction : rx_val
	// Two whole containers with a stalling sink
	task automatic tx_container();
		int s, n;
		s = 0;
		n = 0;
		while (s < 1380 && n < 4000) begin
			@(posedge mclk);
			tx_out_ready <= n[1:0] != 2'h2;
			n++;
			@(negedge mclk);
			if (tx_out_valid && tx_out_ready) begin
				`CHK(tx_out_word, tx_exp(s % 690))
				s++;
			end
		end
		@(posedge mclk);
		tx_out_ready <= 1'b0;
		`CHK(s, 1380)
	endtask : tx_container
	// One received container, then its mother block
	task automatic rx_block(input logic steal, input logic nxt);
		int n, m, a, c0, c1, b2, len, got;
		logic [15:0] v;
		for (int i = 0; i < MEM_DEPTH; i++) exp_q[i] = 16'h0;
		c0 = steal ? 51 : 102;
		c1 = steal ? 84 : 168;
		b2 = steal ? 219 : 438;
		len = steal ? 333 : 654;
		for (n = 0; n < (steal ? 216 : 432); n++) begin
			m = n - c0;
			if (n < c0) a = n;
			else if (n < c0 + c1) a = c0 + 6 * (m / 3) + p23[m % 3] - 1;
			else begin
				m = m - c1;
				a = b2 + (steal ? 24 * (m / 17) + p817[m % 17] : 12 * (m / 9) + p818[m % 9]) - 1;
			end
			exp_q[a] = rx_val(steal ? n + 216 : n);
		end
		for (int s = 0; s < 690; s++) begin
			@(posedge mclk);
			rx_in_valid <= 1'b1;
			rx_in_word <= pidx(s) < 0 ? 16'h7fff : rx_val(pidx(s));
			n = 0;
			@(negedge mclk);
			while (!rx_in_ready && n < 2000) begin
				@(negedge mclk);
				n++;
			end
		end
		@(posedge mclk);
		rx_in_valid <= 1'b0;
		n = 0;
		@(negedge mclk);
		while (!mb_block_ready && n < 3) begin
			@(negedge mclk);
			n++;
		end
		v = rx_val(steal ? 216 : 0);
		`CHK(mb_block_ready, 1'b1)
		`CHK(bad_frame_flag, !v[15])
		@(posedge mclk);
		frame_steal <= nxt;
		stall <= 1'b1;
		got = 0;
		n = 0;
		while (got < len && n < 4000) begin
			@(negedge mclk);
			n++;
			if (mb_valid && mb_ready) begin
				`CHK(mb_word, exp_q[got])
				got++;
			end
		end
		`CHK(got, len)
	endtask : rx_block
	// Report and stop
	task automatic wrap_up();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up
	// Main sequence
	initial begin
		repeat (3) @(posedge mclk);
		`CHK(tx_in_ready, 1'b1)
		`CHK(mb_valid, 1'b0)
		rst_n <= 1'b1;
		tx_container();
		rx_block(1'b0, 1'b1);
		rx_block(1'b1, 1'b0);
		wrap_up();
	end
endmodule : tb_sfd_depuncture
bind sfd_depuncture sfd_depuncture_assertions sfd_depuncture_assertions_inst (.mclk, .rst_n,
	.tx_in_valid, .tx_in_ready, .tx_out_word, .tx_out_valid, .tx_out_ready, .rx_in_ready,
	.mb_word, .mb_valid, .mb_ready, .mb_block_ready);
